/* File: core/lpc_port_ctrl.sv */
module lpc_port_ctrl
  import lpc_pkg::*;
#(
  parameter int NB = 4,
  parameter int CW = 16
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic I_RST_PIN_N,
  input wire logic I_GLOBAL_RST,
  input wire logic [6:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WE,
  input wire logic I_RE,
  output logic [15:0] O_RDATA,
  input wire logic I_GLOBAL_ERR_INSERT,
  input wire logic I_GLOBAL_PM_UPDATE,
  input wire logic [NB-1:0] I_BLOCK_PM_OPTIN,
  input wire logic [NB-1:0] I_BLOCK_PM_DONE,
  input wire logic I_CODE_VIOL_EVT,
  output logic O_ERR_INSERT,
  output logic O_PM_UPDATE,
  output logic O_DATAPATH_CLEAR,
  output logic [CW-1:0] O_PM_COUNT,
  input wire logic I_TX_LINE_CLOCK,
  input wire logic I_FIRST_PORT_TX_CLOCK,
  input wire logic I_TX_POSITIVE_RAIL,
  input wire logic I_TX_NEGATIVE_RAIL,
  output logic O_LINE_OUT_PLUS,
  output logic O_LINE_OUT_PLUS_OE_N,
  output logic O_LINE_OUT_MINUS,
  output logic O_LINE_OUT_MINUS_OE_N,
  input wire logic I_RX_LINE_CLOCK,
  input wire logic I_RX_LINE_PLUS,
  input wire logic I_RX_LINE_MINUS,
  output logic O_RX_POSITIVE_RAIL,
  output logic O_RX_NEGATIVE_RAIL,
  output logic O_RX_CLOCK,
  output logic O_RX_OE_N,
  output logic [1:0] O_LINE_RATE,
  output logic O_PATTERN_GEN_ON,
  output logic O_PATTERN_DIRECTION,
  output logic O_SCRAMBLE_EN,
  output logic O_ALARM_FRAMED,
  output logic O_DIAG_LOOP,
  output logic O_LINE_LOOP,
  output logic O_ANALOG_LOOP,
  input wire logic I_DECODER_PEND,
  input wire logic I_LINE_UNIT_PEND,
  input wire logic I_PATTERN_PEND,
  input wire logic I_GLOBAL_PORT_EN,
  output logic O_IRQ
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  assign pin_raw = {I_RST_PIN_N, I_RX_LINE_MINUS, I_RX_LINE_PLUS,
    I_RX_LINE_CLOCK, I_TX_NEGATIVE_RAIL, I_TX_POSITIVE_RAIL,
    I_FIRST_PORT_TX_CLOCK, I_TX_LINE_CLOCK};
  // a change is taken only once stages two and three agree
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
        s1_q[g] <= PIN_RST[g];
        s2_q[g] <= PIN_RST[g];
        s3_q[g] <= PIN_RST[g];
        pin_q[g] <= PIN_RST[g];
      end else if (I_CE) begin
        s1_q[g] <= pin_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) pin_q[g] <= s3_q[g];
      end
    end
  end

  // ****************************************
  // resets
  // ****************************************
  logic [15:0] ctrl1_q, ctrl2_q, ctrl3_q, pol_q;
  logic [15:0] lat_q, stat_en_q, sum_en_q;
  logic hard_rst, port_rst, eff_rst, dp_rst;
  logic [3:0] rst_cnt_q;
  // soft bit survives its own reset, so only hard sources clear it
  assign hard_rst = I_SYS_RST | I_GLOBAL_RST | ~pin_q[7];
  assign port_rst = hard_rst | ctrl1_q[B_SOFT_RST];
  assign eff_rst = port_rst | (rst_cnt_q != 4'h0);
  assign dp_rst = eff_rst | ctrl1_q[B_DP_CLR];

  // stretch so a one-cycle pulse still spans the least reset time
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) rst_cnt_q <= RST_CYC;
    else if (I_CE) begin
      if (port_rst) rst_cnt_q <= RST_CYC;
      else if (rst_cnt_q != 4'h0) rst_cnt_q <= rst_cnt_q - 4'h1;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic wr1, wr2, wr3, wrp, wrl, wrs, wre;
  logic [15:0] sum_w, rd_d;
  assign wr1 = I_WE && (I_ADDR == ADDR_CTRL1);
  assign wr2 = I_WE && (I_ADDR == ADDR_CTRL2);
  assign wr3 = I_WE && (I_ADDR == ADDR_CTRL3);
  assign wrp = I_WE && (I_ADDR == ADDR_POL);
  assign wrl = I_WE && (I_ADDR == ADDR_LATCH);
  assign wrs = I_WE && (I_ADDR == ADDR_STAT_EN);
  assign wre = I_WE && (I_ADDR == ADDR_SUM_EN);

  // writes land masked so unused bits stay zero
  always_ff @(posedge I_CLK) begin
    if (hard_rst) ctrl1_q <= RST_VAL;
    else if (I_CE) begin
      // the soft bit stays writable, else software could never leave its own reset
      if (eff_rst) ctrl1_q <= RST_VAL | ((wr1 ? I_WDATA : ctrl1_q) & 16'h0001);
      else if (wr1) ctrl1_q <= I_WDATA & MASK_CTRL1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (eff_rst) begin
      ctrl2_q <= RST_VAL;
      ctrl3_q <= RST_VAL;
      pol_q <= RST_VAL;
      stat_en_q <= RST_VAL;
      sum_en_q <= RST_VAL;
    end else if (I_CE) begin
      if (wr2) ctrl2_q <= I_WDATA & MASK_CTRL2;
      if (wr3) ctrl3_q <= I_WDATA & MASK_CTRL3;
      if (wrp) pol_q <= I_WDATA & MASK_POL;
      if (wrs) stat_en_q <= I_WDATA & MASK_LATCH;
      if (wre) sum_en_q <= I_WDATA & MASK_SUM_EN;
    end
  end

  // unmapped offsets read as zero
  assign rd_d = (I_ADDR == ADDR_CTRL1) ? ctrl1_q :
                (I_ADDR == ADDR_CTRL2) ? ctrl2_q :
                (I_ADDR == ADDR_CTRL3) ? ctrl3_q :
                (I_ADDR == ADDR_POL) ? pol_q :
                (I_ADDR == ADDR_SUM) ? sum_w :
                (I_ADDR == ADDR_LATCH) ? lat_q :
                (I_ADDR == ADDR_STAT_EN) ? stat_en_q :
                (I_ADDR == ADDR_SUM_EN) ? sum_en_q : 16'h0000;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) O_RDATA <= 16'h0000;
    else if (I_CE && I_RE) O_RDATA <= rd_d;
  end

  // ****************************************
  // error insertion and pm update triggers
  // ****************************************
  logic err_lvl, err_prev_q, pm_lvl, pm_prev_q, pm_upd;
  logic loc_done_q, pm_done_q, pm_done_prev_q, blk_done;
  logic [CW-1:0] cnt_q;
  assign err_lvl = ctrl1_q[B_ERR_SRC] ? I_GLOBAL_ERR_INSERT
                                      : ctrl1_q[B_ERR_TRIG];
  assign pm_lvl = ctrl1_q[B_PM_SRC] ? I_GLOBAL_PM_UPDATE
                                    : ctrl1_q[B_PM_REQ];
  assign pm_upd = pm_lvl & ~pm_prev_q & ~dp_rst;
  // blocks that did not opt in count as done
  assign blk_done = &(I_BLOCK_PM_DONE | ~I_BLOCK_PM_OPTIN);

  // rising edges only: a held level inserts or updates once
  always_ff @(posedge I_CLK) begin
    if (dp_rst) begin
      err_prev_q <= 1'b0;
      pm_prev_q <= 1'b0;
      O_ERR_INSERT <= 1'b0;
      O_PM_UPDATE <= 1'b0;
    end else if (I_CE) begin
      err_prev_q <= err_lvl;
      pm_prev_q <= pm_lvl;
      O_ERR_INSERT <= err_lvl & ~err_prev_q;
      O_PM_UPDATE <= pm_upd;
    end
  end

  // done holds until the request level drops
  always_ff @(posedge I_CLK) begin
    if (dp_rst) begin
      loc_done_q <= 1'b0;
      pm_done_q <= 1'b0;
      pm_done_prev_q <= 1'b0;
    end else if (I_CE) begin
      if (!pm_lvl) loc_done_q <= 1'b0;
      else if (pm_upd) loc_done_q <= 1'b1;
      pm_done_q <= pm_lvl & loc_done_q & blk_done;
      pm_done_prev_q <= pm_done_q;
    end
  end

  // line code violation counter with update snapshot
  always_ff @(posedge I_CLK) begin
    if (dp_rst) begin
      cnt_q <= '0;
      O_PM_COUNT <= '0;
    end else if (I_CE) begin
      if (pm_upd) begin
        O_PM_COUNT <= cnt_q;
        cnt_q <= CW'(I_CODE_VIOL_EVT);
      end else if (I_CODE_VIOL_EVT && (cnt_q != '1)) cnt_q <= cnt_q + 1'b1;
    end
  end

  // ****************************************
  // latched status and summary
  // ****************************************
  logic [15:0] lat_set;
  logic tx_clk_edge;
  assign lat_set[B_L_PM] = pm_done_q & ~pm_done_prev_q;
  assign lat_set[B_L_NZ] = I_CODE_VIOL_EVT;
  assign lat_set[B_L_TX_LINE_CLOCK] = tx_clk_edge;
  assign lat_set[7:2] = 6'h00;
  assign lat_set[15:9] = 7'h00;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge I_CLK) begin
    if (dp_rst) lat_q <= RST_VAL;
    else if (I_CE) begin
      lat_q <= ((lat_q & ~(wrl ? I_WDATA : 16'h0000)) | lat_set) & MASK_LATCH;
    end
  end

  assign sum_w = {12'h000, I_DECODER_PEND, I_LINE_UNIT_PEND,
    I_PATTERN_PEND, |(lat_q & stat_en_q)};
  assign O_IRQ = (|(sum_w & sum_en_q)) & I_GLOBAL_PORT_EN;

  // ****************************************
  // transmit path
  // ****************************************
  logic tx_pd, tx_clk, tx_prev_q, tx_smp, tx_p, tx_n, tx_bit, alt_q;
  assign tx_pd = ctrl1_q[B_TX_PD];
  assign tx_clk = ctrl2_q[B_TX_SHARED] ? pin_q[1] : pin_q[0];
  assign tx_clk_edge = tx_clk ^ tx_prev_q;
  // clock invert picks the falling edge for sampling
  assign tx_smp = ~tx_pd & (pol_q[B_TXC_POL] ? (tx_prev_q & ~tx_clk)
                                              : (~tx_prev_q & tx_clk));
  assign tx_p = pin_q[2] ^ pol_q[B_TXP_POL];
  assign tx_n = pin_q[3] ^ pol_q[B_TXN_POL];
  assign tx_bit = ctrl3_q[B_AL_SEND] | tx_p;

  // power-down freezes the path like a stopped clock
  always_ff @(posedge I_CLK) begin
    if (dp_rst) begin
      tx_prev_q <= 1'b0;
      alt_q <= 1'b0;
      O_LINE_OUT_PLUS <= 1'b0;
      O_LINE_OUT_MINUS <= 1'b0;
    end else if (I_CE && !tx_pd) begin
      tx_prev_q <= tx_clk;
      if (tx_smp) begin
        if (ctrl2_q[B_TX_SR] || ctrl3_q[B_AL_SEND]) begin
          O_LINE_OUT_PLUS <= tx_bit & ~alt_q;
          O_LINE_OUT_MINUS <= tx_bit & alt_q;
          alt_q <= alt_q ^ tx_bit;
        end else begin
          O_LINE_OUT_PLUS <= tx_p;
          O_LINE_OUT_MINUS <= tx_n;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (eff_rst) begin
      O_LINE_OUT_PLUS_OE_N <= 1'b0;
      O_LINE_OUT_MINUS_OE_N <= 1'b0;
    end else if (I_CE) begin
      O_LINE_OUT_PLUS_OE_N <= tx_pd;
      O_LINE_OUT_MINUS_OE_N <= tx_pd;
    end
  end

  // ****************************************
  // receive path
  // ****************************************
  logic rx_pd, rx_rise, rx_prev_q, rx_mark, last_q, rx_viol;
  assign rx_pd = ctrl1_q[B_RX_PD];
  assign rx_rise = pin_q[4] & ~rx_prev_q;
  assign rx_mark = pin_q[5] | pin_q[6];
  // two marks in a row with one polarity break alternation
  assign rx_viol = rx_mark & (pin_q[6] == last_q);

  always_ff @(posedge I_CLK) begin
    if (dp_rst) begin
      rx_prev_q <= 1'b0;
      last_q <= 1'b1;
      O_RX_POSITIVE_RAIL <= 1'b0;
      O_RX_NEGATIVE_RAIL <= 1'b0;
      O_RX_CLOCK <= 1'b0;
    end else if (I_CE && !rx_pd) begin
      rx_prev_q <= pin_q[4];
      O_RX_CLOCK <= pin_q[4] ^ ~pol_q[B_RXC_POL];
      if (rx_rise) begin
        if (rx_mark) last_q <= pin_q[6];
        if (ctrl2_q[B_RX_SR]) begin
          O_RX_POSITIVE_RAIL <= rx_mark ^ pol_q[B_RXP_POL];
          O_RX_NEGATIVE_RAIL <= rx_viol ^ pol_q[B_RXN_POL];
        end else begin
          O_RX_POSITIVE_RAIL <= pin_q[5] ^ pol_q[B_RXP_POL];
          O_RX_NEGATIVE_RAIL <= pin_q[6] ^ pol_q[B_RXN_POL];
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (eff_rst) O_RX_OE_N <= 1'b0;
    else if (I_CE) O_RX_OE_N <= rx_pd | ctrl2_q[B_RX_OFF];
  end

  // ****************************************
  // mode decode
  // ****************************************
  lpc_rate_t rate;
  assign rate = lpc_rate_t'(ctrl2_q[B_RATE +: 2]);
  assign O_LINE_RATE = rate;
  assign O_DATAPATH_CLEAR = dp_rst;
  assign O_PATTERN_GEN_ON = ctrl3_q[B_PAT_ON];
  assign O_PATTERN_DIRECTION = ctrl3_q[B_PAT_DIR];
  assign O_ALARM_FRAMED = ctrl3_q[B_AL_SEND] & ctrl3_q[B_AL_TYPE]
    & (rate != RATE_E3);
  assign O_SCRAMBLE_EN = O_ALARM_FRAMED & (rate == RATE_STS1)
    & ~ctrl3_q[B_SCR_OFF];
  assign O_DIAG_LOOP = ctrl3_q[B_LOOP] & ~(ctrl3_q[B_LOOP + 1]
    & ctrl3_q[B_LOOP_VAR]);
  assign O_LINE_LOOP = ctrl3_q[B_LOOP + 1] & ~(ctrl3_q[B_LOOP]
    & ctrl3_q[B_LOOP_VAR]);
  assign O_ANALOG_LOOP = &ctrl3_q[B_LOOP +: 2] & ctrl3_q[B_LOOP_VAR];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST || !I_CE);
  a_err_edge: assert property ((err_lvl && !err_prev_q && !dp_rst)
    |=> O_ERR_INSERT) else $error("error insert pulse missing");
  a_err_src: assert property (O_ERR_INSERT |-> $past(err_lvl))
    else $error("error insert from wrong source");
  a_pm_snap: assert property (pm_upd |=> O_PM_UPDATE
    && O_PM_COUNT == $past(cnt_q)) else $error("pm snapshot wrong");
  a_pm_src: assert property (O_PM_UPDATE |-> $past(pm_lvl))
    else $error("pm update from wrong source");
  a_done_clr: assert property (!pm_lvl |=> !pm_done_q)
    else $error("done not cleared");
  a_cnt_one: assert property ((pm_upd && I_CODE_VIOL_EVT)
    |=> cnt_q == 1 && lat_q[B_L_NZ]) else $error("count not one");
  a_tx_hiz: assert property (tx_pd && !eff_rst |=>
    O_LINE_OUT_PLUS_OE_N && O_LINE_OUT_MINUS_OE_N) else $error("tx driven");
  a_rx_hiz: assert property ((rx_pd || ctrl2_q[B_RX_OFF]) && !eff_rst
    |=> O_RX_OE_N) else $error("rx driven");
  a_dp_clear: assert property (ctrl1_q[B_DP_CLR] |=> cnt_q == 0
    && lat_q == 0) else $error("datapath not cleared");
  a_soft_rst: assert property (port_rst |=> ctrl3_q == 0
    && ctrl2_q == 0) else $error("soft reset incomplete");
  a_irq_gate: assert property (O_IRQ |-> I_GLOBAL_PORT_EN
    && |(sum_w & sum_en_q)) else $error("irq without enable");
  c_err: cover property (O_ERR_INSERT);
  c_pm_done: cover property (O_PM_UPDATE ##[1:20] pm_done_q);
  c_irq: cover property (O_IRQ);
endmodule // lpc_port_ctrl

/* File: core/lpc_pkg.sv */
package lpc_pkg;
  // ****************************************
  // register map (16-bit port registers)
  // ****************************************
  localparam logic [6:0] ADDR_CTRL1 = 7'h00;
  localparam logic [6:0] ADDR_CTRL2 = 7'h02;
  localparam logic [6:0] ADDR_CTRL3 = 7'h04;
  localparam logic [6:0] ADDR_POL = 7'h06;
  localparam logic [6:0] ADDR_SUM = 7'h08;
  localparam logic [6:0] ADDR_LATCH = 7'h0A;
  localparam logic [6:0] ADDR_STAT_EN = 7'h0C;
  localparam logic [6:0] ADDR_SUM_EN = 7'h0E;
  // implemented bits; everything else reads zero
  localparam logic [15:0] MASK_CTRL1 = 16'h00FF;
  localparam logic [15:0] MASK_CTRL2 = 16'h00DE;
  localparam logic [15:0] MASK_CTRL3 = 16'h039F;
  localparam logic [15:0] MASK_POL = 16'h0077;
  localparam logic [15:0] MASK_LATCH = 16'h0103;
  localparam logic [15:0] MASK_SUM_EN = 16'h000F;
  localparam logic [15:0] RST_VAL = 16'h0000;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_ERR_TRIG = 7;
  localparam int B_ERR_SRC = 6;
  localparam int B_PM_SRC = 5;
  localparam int B_PM_REQ = 4;
  localparam int B_TX_PD = 3;
  localparam int B_RX_PD = 2;
  localparam int B_DP_CLR = 1;
  localparam int B_SOFT_RST = 0;
  localparam int B_RATE = 6;
  localparam int B_RX_OFF = 4;
  localparam int B_TX_SR = 3;
  localparam int B_RX_SR = 2;
  localparam int B_TX_SHARED = 1;
  localparam int B_PAT_ON = 9;
  localparam int B_PAT_DIR = 8;
  localparam int B_SCR_OFF = 7;
  localparam int B_AL_TYPE = 4;
  localparam int B_AL_SEND = 3;
  localparam int B_LOOP_VAR = 2;
  localparam int B_LOOP = 0;
  localparam int B_TXN_POL = 6;
  localparam int B_TXP_POL = 5;
  localparam int B_TXC_POL = 4;
  localparam int B_RXN_POL = 2;
  localparam int B_RXP_POL = 1;
  localparam int B_RXC_POL = 0;
  localparam int B_L_PM = 0;
  localparam int B_L_NZ = 1;
  localparam int B_L_TX_LINE_CLOCK = 8;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int MIN_RST_NS = 100;
  localparam int RST_CYC_I = (MIN_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RST_CYC = 4'(RST_CYC_I < 1 ? 1 : RST_CYC_I);
  // pin synchroniser slots, reset pin idles high
  localparam int NPIN = 8;
  localparam logic [NPIN-1:0] PIN_RST = 8'h80;
  typedef enum logic [1:0] {RATE_DS3, RATE_E3, RATE_STS1, RATE_RSVD} lpc_rate_t;
endpackage : lpc_pkg

/* File: sim/lpc_port_ctrl_tb.sv */
module lpc_port_ctrl_tb
  import lpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus signals
  // ****************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic glb_rst = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic g_err = 1'b0;
  logic g_pm = 1'b0;
  logic [3:0] optin = 4'h0;
  logic [3:0] bdone = 4'h0;
  logic viol = 1'b0;
  logic [3:0] pend = 4'h0;
  logic [7:0] pin_cnt = 8'h00;
  logic [15:0] rdata, pm_cnt;
  logic err_ins, pm_upd, dp_clr, lo_p, lo_p_oe_n, lo_n, lo_n_oe_n;
  logic rxp, rxn, rxc, rx_oe_n, pat_on, pat_dir, scr_en, al_fr, dg_lp, ln_lp, an_lp, irq;
  logic [1:0] rate;
  int fail_count = 0;
  int compares = 0;
  int err_n = 0;
  int pm_n = 0;
  // 10 MHz system clock
  always #50 clk = ~clk;
  lpc_port_ctrl dut (
    .I_CLK(clk), .I_SYS_RST(sys_rst), .I_CE(1'b1), .I_RST_PIN_N(1'b1),
    .I_GLOBAL_RST(glb_rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WE(we), .I_RE(re),
    .O_RDATA(rdata), .I_GLOBAL_ERR_INSERT(g_err), .I_GLOBAL_PM_UPDATE(g_pm),
    .I_BLOCK_PM_OPTIN(optin), .I_BLOCK_PM_DONE(bdone), .I_CODE_VIOL_EVT(viol),
    .O_ERR_INSERT(err_ins), .O_PM_UPDATE(pm_upd), .O_DATAPATH_CLEAR(dp_clr),
    .O_PM_COUNT(pm_cnt), .I_TX_LINE_CLOCK(pin_cnt[2]), .I_FIRST_PORT_TX_CLOCK(pin_cnt[3]),
    .I_TX_POSITIVE_RAIL(pin_cnt[5]), .I_TX_NEGATIVE_RAIL(pin_cnt[6]),
    .O_LINE_OUT_PLUS(lo_p), .O_LINE_OUT_PLUS_OE_N(lo_p_oe_n), .O_LINE_OUT_MINUS(lo_n),
    .O_LINE_OUT_MINUS_OE_N(lo_n_oe_n), .I_RX_LINE_CLOCK(pin_cnt[1]),
    .I_RX_LINE_PLUS(pin_cnt[4]), .I_RX_LINE_MINUS(pin_cnt[7]), .O_RX_POSITIVE_RAIL(rxp),
    .O_RX_NEGATIVE_RAIL(rxn), .O_RX_CLOCK(rxc), .O_RX_OE_N(rx_oe_n), .O_LINE_RATE(rate),
    .O_PATTERN_GEN_ON(pat_on), .O_PATTERN_DIRECTION(pat_dir), .O_SCRAMBLE_EN(scr_en),
    .O_ALARM_FRAMED(al_fr), .O_DIAG_LOOP(dg_lp), .O_LINE_LOOP(ln_lp), .O_ANALOG_LOOP(an_lp),
    .I_DECODER_PEND(pend[3]), .I_LINE_UNIT_PEND(pend[2]), .I_PATTERN_PEND(pend[1]),
    .I_GLOBAL_PORT_EN(pend[0]), .O_IRQ(irq)
  );
  // line pins keep toggling so the synchronisers always see traffic
  always @(negedge clk) begin
    pin_cnt <= pin_cnt + 8'h01;
  end
  // count one-cycle trigger pulses; a held level must yield exactly one
  always @(posedge clk) begin
    if (err_ins === 1'b1) err_n++;
    if (pm_upd === 1'b1) pm_n++;
  end
  // ****************************************
  // access tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clk);
    we = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read waits one spare cycle since the data register holds until the next read
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    @(negedge clk);
    re = 1'b1;
    addr = a;
    @(negedge clk);
    re = 1'b0;
    cyc(1);
    chk(rdata, exp);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    #(5000 * CLK_NS);
    fail_count++;
    end_sim;
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    cyc(3);
    sys_rst = 1'b0;
    cyc(4);
    rchk(ADDR_CTRL1, RST_VAL);
    rchk(ADDR_CTRL3, RST_VAL);
    chk(16'({lo_p_oe_n, lo_n_oe_n, rx_oe_n}), 16'h0000);
    tdone("reset");
    // masked read-back, read-only and unmapped places
    wr(ADDR_CTRL1, 16'hFFFE);
    rchk(ADDR_CTRL1, 16'h00FE);
    chk(16'({lo_p_oe_n, lo_n_oe_n, rx_oe_n, dp_clr}), 16'h000F);
    wr(ADDR_CTRL1, 16'h0000);
    chk(16'(dp_clr), 16'h0000);
    wr(ADDR_CTRL2, 16'hFFFF);
    rchk(ADDR_CTRL2, MASK_CTRL2);
    chk(16'(rx_oe_n), 16'h0001);
    wr(ADDR_CTRL3, 16'hFFFF);
    rchk(ADDR_CTRL3, MASK_CTRL3);
    wr(ADDR_POL, 16'hFFFF);
    rchk(ADDR_POL, MASK_POL);
    wr(ADDR_SUM, 16'hFFFF);
    rchk(ADDR_SUM, 16'h0000);
    wr(7'h10, 16'hFFFF);
    rchk(7'h10, 16'h0000);
    wr(ADDR_CTRL2, 16'h0000);
    wr(ADDR_CTRL3, 16'h0000);
    wr(ADDR_POL, 16'h0000);
    wr(ADDR_CTRL1, 16'h0004);
    // the enable flops follow the control bit one edge later
    cyc(1);
    chk(16'({lo_p_oe_n, rx_oe_n}), 16'h0001);
    wr(ADDR_CTRL1, 16'h0000);
    tdone("registers");
    // every rate code and every loop code
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CTRL2, 16'(r << B_RATE));
      chk(16'(rate), 16'(r));
    end
    for (int v = 0; v < 8; v++) begin
      wr(ADDR_CTRL3, 16'(v));
      chk(16'({dg_lp, ln_lp, an_lp}), 16'({(v[1:0] == 2'b01) || (v[2:0] == 3'b011),
          (v[1:0] == 2'b10) || (v[2:0] == 3'b011), v[2:0] == 3'b111}));
    end
    wr(ADDR_CTRL3, 16'h0300);
    chk(16'({pat_on, pat_dir}), 16'h0003);
    wr(ADDR_CTRL3, 16'h0200);
    chk(16'({pat_on, pat_dir}), 16'h0002);
    wr(ADDR_CTRL2, 16'h0080);
    wr(ADDR_CTRL3, 16'h0018);
    chk(16'({al_fr, scr_en}), 16'h0003);
    wr(ADDR_CTRL3, 16'h0098);
    chk(16'(scr_en), 16'h0000);
    wr(ADDR_CTRL3, 16'h0008);
    chk(16'(al_fr), 16'h0000);
    tdone("decodes");
    // manual and global error triggers, held levels give one pulse
    err_n = 0;
    wr(ADDR_CTRL1, 16'h0080);
    cyc(4);
    chk(16'(err_n), 16'h0001);
    wr(ADDR_CTRL1, 16'h00C0);
    cyc(4);
    chk(16'(err_n), 16'h0001);
    g_err = 1'b1;
    cyc(4);
    chk(16'(err_n), 16'h0002);
    g_err = 1'b0;
    wr(ADDR_CTRL1, 16'h0020);
    pm_n = 0;
    g_pm = 1'b1;
    cyc(4);
    chk(16'(pm_n), 16'h0001);
    g_pm = 1'b0;
    wr(ADDR_CTRL1, 16'h0000);
    tdone("triggers");
    // counter snapshot, clear, and done from opted-in blocks only
    optin = 4'h3;
    wr(ADDR_LATCH, 16'hFFFF);
    repeat (3) begin
      @(negedge clk) viol = 1'b1;
      @(negedge clk) viol = 1'b0;
    end
    pm_n = 0;
    wr(ADDR_CTRL1, 16'h0010);
    cyc(3);
    chk(16'(pm_n), 16'h0001);
    chk(16'(pm_cnt), 16'h0003);
    // counter-nonzero and tx clock activity are latched too, done is not yet
    rchk(ADDR_LATCH, 16'h0102);
    bdone = 4'h3;
    cyc(3);
    rchk(ADDR_LATCH, 16'h0103);
    wr(ADDR_CTRL1, 16'h0000);
    bdone = 4'h0;
    wr(ADDR_CTRL1, 16'h0010);
    // an event in the very update cycle must leave the counter at one
    viol = 1'b1;
    cyc(1);
    viol = 1'b0;
    cyc(2);
    chk(16'(pm_cnt), 16'h0000);
    wr(ADDR_CTRL1, 16'h0000);
    wr(ADDR_CTRL1, 16'h0010);
    cyc(3);
    chk(16'(pm_cnt), 16'h0001);
    wr(ADDR_CTRL1, 16'h0000);
    tdone("update");
    // soft reset and global reset clear control registers
    wr(ADDR_CTRL2, 16'h0040);
    wr(ADDR_CTRL1, 16'h0001);
    wr(ADDR_CTRL1, 16'h0000);
    cyc(2);
    rchk(ADDR_CTRL2, 16'h0000);
    wr(ADDR_CTRL2, 16'h0080);
    glb_rst = 1'b1;
    cyc(1);
    glb_rst = 1'b0;
    cyc(3);
    rchk(ADDR_CTRL2, 16'h0000);
    tdone("resets");
    // summary bit and the two-level interrupt gate
    pend = 4'h8;
    cyc(2);
    rchk(ADDR_SUM, 16'h0008);
    chk(16'(irq), 16'h0000);
    wr(ADDR_SUM_EN, 16'h0008);
    chk(16'(irq), 16'h0000);
    pend = 4'h9;
    cyc(2);
    chk(16'(irq), 16'h0001);
    wr(ADDR_STAT_EN, 16'h0100);
    rchk(ADDR_SUM, 16'h0009);
    pend = 4'h0;
    tdone("summary");
    end_sim;
  end
endmodule // lpc_port_ctrl_tb
